//--- rtl/utaux_consts.svh
// constants for the uart interrupt, counter/timer and aux output block
`ifndef UTAUX_CONSTS_SVH
`define UTAUX_CONSTS_SVH

`define UTAUX_OFF_ACR 4'h0
`define UTAUX_OFF_ISR 4'h1
`define UTAUX_OFF_IMR 4'h2
`define UTAUX_OFF_PRESET_HIGH_BYTE 4'h3
`define UTAUX_OFF_PRESET_LOW_BYTE 4'h4
`define UTAUX_OFF_CMD 4'h5

`define UTAUX_CMD_START 4'h1
`define UTAUX_CMD_STOP 4'h2
`define UTAUX_CMD_CLR_COS 4'h3
`define UTAUX_CMD_CLR_BRK 4'h4
`define UTAUX_CMD_RTS_ON 4'h5
`define UTAUX_CMD_RTS_OFF 4'h6

`define UTAUX_ACR_TIMER 6
`define UTAUX_ACR_SRC_HI 5
`define UTAUX_ACR_SRC_LO 4
`define UTAUX_ACR_OSEL_HI 2

`define UTAUX_SRC_PIN 2'h0
`define UTAUX_SRC_PIN16 2'h1
`define UTAUX_SRC_CLK 2'h2
`define UTAUX_SRC_REF16 2'h3

`define UTAUX_OSEL_RTS 3'h0
`define UTAUX_OSEL_CT 3'h1
`define UTAUX_OSEL_TX1X 3'h2
`define UTAUX_OSEL_TX16X 3'h3
`define UTAUX_OSEL_RX1X 3'h4
`define UTAUX_OSEL_RX16X 3'h5
`define UTAUX_OSEL_TX_READY_FLAG 3'h6
`define UTAUX_OSEL_RXRDY 3'h7

`define UTAUX_ACR_RST 8'h00
`define UTAUX_IMR_RST 8'h00
`define UTAUX_PRESET_RST 16'h0002
`define UTAUX_DIV16_LAST 4'hf
`define UTAUX_FIFO_FULL 2'h3

`endif

//--- rtl/utaux_pkg.sv
// types shared by the uart interrupt, counter/timer and aux output block
package utaux_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } utaux_bus_t;

    typedef struct packed {
        logic tx_ready_flag;
        logic tx_empty_flag;
        logic [1:0] rx_fifo_level;
        logic rx_shift_full;
        logic break_change;
        logic tx_clk_1x;
        logic tx_clk_16x;
        logic rx_clk_1x;
        logic rx_clk_16x;
        logic rx_full_sel;
        logic rx_rts_ctrl;
        logic tx_rts_ctrl;
    } utaux_chan_t;

    typedef enum logic [1:0] {
        CT_STOPPED,
        CT_COUNTING,
        CT_TERMINAL
    } utaux_ct_state_t;

endpackage

//--- rtl/utaux_top.sv
// interrupt status/mask, 16-bit counter/timer and aux output selector
// How it works
// R1 - code 000: rts low, commands, auto negate
// R2 - code 001: counter/timer output on aux pin
// R3 - codes 010/011: transmitter 1x and 16x clocks
// R4 - codes 100/101: receiver 1x and 16x clocks
// R5 - code 110: inverted transmitter ready flag
// R6 - code 111: inverted status bit two
// R7 - interrupt low when status and mask bits
// R8 - status reads unmasked, cleared on reset
// R9 - bit 7 sets on input change, command clears
// R10 - bit 6 is input level latched at read
// R11 - counter: bit 4 at terminal, stop clears
// R12 - timer: bit 4 once per wave, stop clears
// R13 - bit 3 break change, command clears
// R14 - bit 2 as receiver ready
// R15 - bit 2 as fifo full
// R16 - bits 1,0 mirror tx empty, tx ready
// R17 - mask bit 6 with high input interrupts
// R18 - 16-bit preset from two byte registers
// R19 - software never loads preset below two
// R20 - timer period twice preset, next half
// R21 - counter starts on command, runs past zero
// R22 - counter preset used only at start
// R23 - control bit 6 picks counter or timer
// R24 - timer reloads at zero and toggles wave
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "utaux_consts.svh"

module utaux_top
    import utaux_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire utaux_bus_t BUS,
    output logic [7:0] RDATA,
    input wire utaux_chan_t CHAN,
    input wire logic AUX_INPUT_PIN,
    output logic AUX_OUTPUT_PIN,
    output logic IRQ_OUT_N
);

    logic [7:0] aux_control_reg_q;
    logic [7:0] irq_mask_reg_q;
    logic [7:0] preset_high_byte_q;
    logic [7:0] preset_low_byte_q;
    logic [15:0] preset;
    logic [15:0] cnt_q;
    logic [3:0] pin_div_q;
    logic [3:0] ref_div_q;
    logic pin_prev_q;
    logic tx1x_prev_q;
    logic tx_empty_prev_q;
    logic sq_q;
    utaux_ct_state_t ct_state_q;
    logic cos_q;
    logic pin_latch_q;
    logic brk_q;
    logic ctr_rdy_q;
    logic request_to_send_n_q;
    logic aux_q;
    logic irq_n_q;
    logic [7:0] rdata_q;
    logic cmd_wr;
    logic cmd_start;
    logic cmd_stop;
    logic timer_mode;
    logic tick;
    logic pin_rise;
    logic ct_out;
    logic timer_wrap;
    logic tc_hit;
    logic rx_flag;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_src;

    assign preset = {preset_high_byte_q, preset_low_byte_q}; // [R18]
    assign timer_mode = aux_control_reg_q[`UTAUX_ACR_TIMER]; // [R23]
    assign cmd_wr = BUS.wr && (BUS.addr == `UTAUX_OFF_CMD);
    assign cmd_start = cmd_wr && (BUS.wdata[3:0] == `UTAUX_CMD_START);
    assign cmd_stop = cmd_wr && (BUS.wdata[3:0] == `UTAUX_CMD_STOP);
    assign pin_rise = AUX_INPUT_PIN && !pin_prev_q;

    // register writes; imr and preset bytes are write-only
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aux_control_reg_q <= `UTAUX_ACR_RST;
            irq_mask_reg_q <= `UTAUX_IMR_RST;
            preset_high_byte_q <= 8'(`UTAUX_PRESET_RST >> 8);
            preset_low_byte_q <= 8'(`UTAUX_PRESET_RST);
        end else if (BUS.wr) begin
            unique case (BUS.addr)
                `UTAUX_OFF_ACR: aux_control_reg_q <= BUS.wdata;
                `UTAUX_OFF_IMR: irq_mask_reg_q <= BUS.wdata;
                `UTAUX_OFF_PRESET_HIGH_BYTE: preset_high_byte_q <= BUS.wdata; // [R18]
                `UTAUX_OFF_PRESET_LOW_BYTE: preset_low_byte_q <= BUS.wdata; // [R18]
                default: ;
            endcase
        end
    end

    // edge history for the input pin, transmitter clock and tx empty
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_prev_q <= 1'b0;
            tx1x_prev_q <= 1'b0;
            tx_empty_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= AUX_INPUT_PIN;
            tx1x_prev_q <= CHAN.tx_clk_1x;
            tx_empty_prev_q <= CHAN.tx_empty_flag;
        end
    end

    // divide-by-16 prescalers for the pin and reference clock sources
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_div_q <= 4'h0;
            ref_div_q <= 4'h0;
        end else begin
            ref_div_q <= ref_div_q + 4'h1;
            if (pin_rise) begin
                pin_div_q <= pin_div_q + 4'h1;
            end
        end
    end

    // clock source select: code 10 is the tx 1x clock when counting
    always_comb begin
        unique case (aux_control_reg_q[`UTAUX_ACR_SRC_HI:`UTAUX_ACR_SRC_LO]) // [R23]
            `UTAUX_SRC_PIN: tick = pin_rise;
            `UTAUX_SRC_PIN16: tick = pin_rise && (pin_div_q == `UTAUX_DIV16_LAST);
            `UTAUX_SRC_CLK: tick = timer_mode ? 1'b1 : (CHAN.tx_clk_1x && !tx1x_prev_q);
            `UTAUX_SRC_REF16: tick = (ref_div_q == `UTAUX_DIV16_LAST);
        endcase
    end

    // preset below two is not guarded; software keeps it legal [R19]
    assign timer_wrap = timer_mode && tick && (cnt_q <= 16'h0001); // [R24]
    assign tc_hit = !timer_mode && tick && (ct_state_q == CT_COUNTING)
        && (cnt_q == 16'h0001); // [R11]

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= `UTAUX_PRESET_RST;
            sq_q <= 1'b1;
        end else if (timer_mode) begin
            if (timer_wrap) begin
                cnt_q <= preset; // [R20] new preset only at half-period end
                sq_q <= !sq_q; // [R24]
            end else if (tick) begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end else if (cmd_start) begin
            cnt_q <= preset; // [R22]
        end else if (tick && (ct_state_q != CT_STOPPED)) begin
            cnt_q <= cnt_q - 16'h0001; // [R21] wraps past zero and keeps going
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ct_state_q <= CT_STOPPED;
        end else if (cmd_start) begin
            ct_state_q <= CT_COUNTING; // [R21]
        end else if (cmd_stop) begin
            ct_state_q <= CT_STOPPED; // [R11]
        end else if (tc_hit) begin
            ct_state_q <= CT_TERMINAL; // [R11]
        end
    end

    assign ct_out = timer_mode ? sq_q : (ct_state_q != CT_TERMINAL); // [R2]

    // counter ready: stop clears, but a simultaneous set wins
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctr_rdy_q <= 1'b0;
        end else if (tc_hit || (timer_wrap && sq_q)) begin
            ctr_rdy_q <= 1'b1; // [R11] [R12] once per wave, on the falling half
        end else if (cmd_stop) begin
            ctr_rdy_q <= 1'b0; // [R11] [R12] timer keeps running
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cos_q <= 1'b0;
        end else if (AUX_INPUT_PIN != pin_prev_q) begin
            cos_q <= 1'b1; // [R9]
        end else if (cmd_wr && (BUS.wdata[3:0] == `UTAUX_CMD_CLR_COS)) begin
            cos_q <= 1'b0; // [R9]
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            brk_q <= 1'b0;
        end else if (CHAN.break_change) begin
            brk_q <= 1'b1; // [R13]
        end else if (cmd_wr && (BUS.wdata[3:0] == `UTAUX_CMD_CLR_BRK)) begin
            brk_q <= 1'b0; // [R13]
        end
    end

    // pin level captured at the status read strobe; must match read data bit 6
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_latch_q <= 1'b0;
        end else if (BUS.rd && (BUS.addr == `UTAUX_OFF_ISR)) begin
            pin_latch_q <= AUX_INPUT_PIN; // [R10]
        end
    end

    // fifo level reflects both fill and read, so set again follows naturally
    assign rx_flag = CHAN.rx_full_sel
        ? ((CHAN.rx_fifo_level == `UTAUX_FIFO_FULL)) // [R15]
        : (CHAN.rx_fifo_level != 2'h0); // [R14]

    assign irq_status_reg = {cos_q, AUX_INPUT_PIN, 1'b0, ctr_rdy_q, brk_q, rx_flag,
        CHAN.tx_empty_flag, CHAN.tx_ready_flag}; // [R16]
    // bit 6 of the source vector is the live pin, so mask bit 6 is level-triggered
    assign irq_src = irq_status_reg & irq_mask_reg_q; // [R17]

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= !(|irq_src); // [R7]
        end
    end

    // rts: pin level register, high means negated
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            request_to_send_n_q <= 1'b1;
        end else if (cmd_wr && (BUS.wdata[3:0] == `UTAUX_CMD_RTS_ON)) begin
            request_to_send_n_q <= 1'b0; // [R1]
        end else if (cmd_wr && (BUS.wdata[3:0] == `UTAUX_CMD_RTS_OFF)) begin
            request_to_send_n_q <= 1'b1; // [R1]
        end else if (CHAN.tx_rts_ctrl && CHAN.tx_empty_flag && !tx_empty_prev_q) begin
            request_to_send_n_q <= 1'b1; // [R1] after last bit shifted out
        end else if (CHAN.rx_rts_ctrl && CHAN.rx_shift_full
            && (CHAN.rx_fifo_level == `UTAUX_FIFO_FULL)) begin
            request_to_send_n_q <= 1'b1; // [R1] receiver fully backed up
        end
    end

    // output select; registered, so the pin lags its source by one cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aux_q <= 1'b1;
        end else begin
            unique case (aux_control_reg_q[`UTAUX_ACR_OSEL_HI:0])
                `UTAUX_OSEL_RTS: aux_q <= request_to_send_n_q; // [R1]
                `UTAUX_OSEL_CT: aux_q <= ct_out; // [R2]
                `UTAUX_OSEL_TX1X: aux_q <= CHAN.tx_clk_1x; // [R3]
                `UTAUX_OSEL_TX16X: aux_q <= CHAN.tx_clk_16x; // [R3]
                `UTAUX_OSEL_RX1X: aux_q <= CHAN.rx_clk_1x; // [R4]
                `UTAUX_OSEL_RX16X: aux_q <= CHAN.rx_clk_16x; // [R4]
                `UTAUX_OSEL_TX_READY_FLAG: aux_q <= !CHAN.tx_ready_flag; // [R5]
                `UTAUX_OSEL_RXRDY: aux_q <= !rx_flag; // [R6]
            endcase
        end
    end

    // read port: data stands one cycle after the strobe, unmapped reads zero
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (BUS.rd) begin
            unique case (BUS.addr)
                `UTAUX_OFF_ACR: rdata_q <= aux_control_reg_q;
                `UTAUX_OFF_ISR: rdata_q <= irq_status_reg; // [R8] [R10] unmasked
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA = rdata_q;
    assign AUX_OUTPUT_PIN = aux_q;
    assign IRQ_OUT_N = irq_n_q;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    property p_irq_asserts; // [R7]
        (|irq_src) |=> !IRQ_OUT_N;
    endproperty
    a_irq_asserts: assert property (p_irq_asserts) else $error("irq not asserted"); // [R7]

    property p_irq_quiet; // [R7]
        !(|irq_src) |=> IRQ_OUT_N;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq asserted without cause"); // [R7]

    property p_cos_sets; // [R9]
        (AUX_INPUT_PIN != pin_prev_q) |=> cos_q;
    endproperty
    a_cos_sets: assert property (p_cos_sets) else $error("change of state missed"); // [R9]

    property p_ct_on_pin; // [R2]
        (aux_control_reg_q[2:0] == `UTAUX_OSEL_CT) |=> (AUX_OUTPUT_PIN == $past(ct_out));
    endproperty
    a_ct_on_pin: assert property (p_ct_on_pin) else $error("aux pin not counter output"); // [R2]

    property p_tx_ready_flag_on_pin; // [R5]
        (aux_control_reg_q[2:0] == `UTAUX_OSEL_TX_READY_FLAG)
            |=> (AUX_OUTPUT_PIN == !$past(CHAN.tx_ready_flag));
    endproperty
    a_tx_ready_flag_on_pin: assert property (p_tx_ready_flag_on_pin) else $error("aux pin not tx ready"); // [R5]

    property p_rxrdy_on_pin; // [R6]
        (aux_control_reg_q[2:0] == `UTAUX_OSEL_RXRDY) |=> (AUX_OUTPUT_PIN == !$past(rx_flag));
    endproperty
    a_rxrdy_on_pin: assert property (p_rxrdy_on_pin) else $error("aux pin not rx ready"); // [R6]

    sequence s_stop_alone;
        cmd_stop && !tc_hit && !(timer_wrap && sq_q) && !cmd_start;
    endsequence
    property p_stop_clears; // [R11]
        s_stop_alone |=> !ctr_rdy_q && (timer_mode || ct_out);
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear"); // [R11]

    sequence s_falling_wrap;
        timer_mode && timer_wrap && sq_q;
    endsequence
    property p_timer_wave; // [R24]
        s_falling_wrap |=> !sq_q && ctr_rdy_q && (cnt_q == $past(preset));
    endproperty
    a_timer_wave: assert property (p_timer_wave) else $error("timer wrap wrong"); // [R24]

    property p_isr_read; // [R8]
        (BUS.rd && BUS.addr == `UTAUX_OFF_ISR)
            |=> (RDATA[6] == $past(AUX_INPUT_PIN)) && (RDATA[1:0] == $past(irq_status_reg[1:0]));
    endproperty
    a_isr_read: assert property (p_isr_read) else $error("status read wrong"); // [R8]

    property p_pin_latch; // [R10]
        (BUS.rd && BUS.addr == `UTAUX_OFF_ISR) |=> (RDATA[6] == pin_latch_q);
    endproperty
    a_pin_latch: assert property (p_pin_latch) else $error("pin level not latched"); // [R10]

    property p_brk_sets; // [R13]
        CHAN.break_change |=> brk_q;
    endproperty
    a_brk_sets: assert property (p_brk_sets) else $error("break change missed"); // [R13]

    property p_tc_sets; // [R11]
        (tc_hit && !cmd_start && !cmd_stop) |=> ctr_rdy_q && (ct_state_q == CT_TERMINAL);
    endproperty
    a_tc_sets: assert property (p_tc_sets) else $error("terminal count missed"); // [R11]

endmodule
`default_nettype wire

//--- dv/utaux_chan_model.sv
// channel-side model: requested flags plus free-running shift clocks
`timescale 1ns/100ps
`default_nettype none
module utaux_chan_model
    import utaux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire utaux_chan_t req,
    output var utaux_chan_t chan
);
    logic [3:0] div_q;
    // clocks never stop, as the real shift clocks run even when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    always_comb begin
        chan = req;
        chan.tx_clk_1x = div_q[3];
        chan.tx_clk_16x = div_q[0];
        chan.rx_clk_1x = div_q[2];
        chan.rx_clk_16x = div_q[1];
    end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the interrupt, counter/timer and aux output block
`timescale 1ns/100ps
`default_nettype none
`include "utaux_consts.svh"
module testbench
    import utaux_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    utaux_bus_t bus = '0;
    utaux_chan_t req = '0;
    utaux_chan_t chan;
    logic pin = 1'b0;
    logic [7:0] rdata;
    logic aux;
    logic irq_n;
    int miscompares = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    utaux_chan_model u_chan (.clk(clk), .rst_n(rst_n), .req(req), .chan(chan));
    utaux_top u_dut (.REF_CLK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata), .CHAN(chan),
        .AUX_INPUT_PIN(pin), .AUX_OUTPUT_PIN(aux), .IRQ_OUT_N(irq_n));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic interrupt_status(output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: `UTAUX_OFF_ISR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask
    task automatic cmd(input logic [3:0] c);
        wr(`UTAUX_OFF_CMD, {4'h0, c});
    endtask
    task automatic pulse();
        pin <= 1'b1;
        cyc(3);
        pin <= 1'b0;
        cyc(3);
    endtask
    task automatic span(input logic v, output int n);
        n = 0;
        while (aux === v && n < 200) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic t_status();
        logic [7:0] d;
        req.tx_ready_flag <= 1'b1;
        req.tx_empty_flag <= 1'b1;
        cyc(2);
        interrupt_status(d);
        chk("isr tx", 8'h03, d);
        chk("irq masked", 8'h01, {7'h00, irq_n});
        wr(`UTAUX_OFF_IMR, 8'h02);
        cyc(2);
        chk("irq on", 8'h00, {7'h00, irq_n});
        wr(`UTAUX_OFF_IMR, 8'h40);
        pin <= 1'b1;
        cyc(3);
        chk("irq pin", 8'h00, {7'h00, irq_n});
        interrupt_status(d);
        chk("isr pin", 8'hc3, d);
        pin <= 1'b0;
        cyc(3);
        cmd(`UTAUX_CMD_CLR_COS);
        interrupt_status(d);
        chk("isr cos clear", 8'h03, d);
        chk("irq pin low", 8'h01, {7'h00, irq_n});
        req.break_change <= 1'b1;
        cyc(1);
        req.break_change <= 1'b0;
        cyc(2);
        interrupt_status(d);
        chk("isr break", 8'h0b, d);
        cmd(`UTAUX_CMD_CLR_BRK);
        interrupt_status(d);
        chk("isr break clear", 8'h03, d);
        $display("test status done");
    endtask

    task automatic t_rts();
        wr(`UTAUX_OFF_ACR, 8'h00);
        cmd(`UTAUX_CMD_RTS_ON);
        cyc(2);
        chk("rts on", 8'h00, {7'h00, aux});
        cmd(`UTAUX_CMD_RTS_OFF);
        cyc(2);
        chk("rts off", 8'h01, {7'h00, aux});
        req.tx_empty_flag <= 1'b0;
        req.tx_rts_ctrl <= 1'b1;
        cmd(`UTAUX_CMD_RTS_ON);
        cyc(2);
        chk("rts held", 8'h00, {7'h00, aux});
        req.tx_empty_flag <= 1'b1;
        cyc(4);
        chk("rts auto", 8'h01, {7'h00, aux});
        req.tx_rts_ctrl <= 1'b0;
        $display("test rts done");
    endtask

    task automatic t_osel();
        logic s;
        logic [7:0] d;
        logic [2:0] tbl [4] = '{3'b001, 3'b101, 3'b111, 3'b000};
        for (int c = 2; c < 7; c++) begin
            wr(`UTAUX_OFF_ACR, {5'h00, 3'(c)});
            cyc(2);
            @(negedge clk);
            case (c)
                2: s = chan.tx_clk_1x;
                3: s = chan.tx_clk_16x;
                4: s = chan.rx_clk_1x;
                5: s = chan.rx_clk_16x;
                default: s = ~chan.tx_ready_flag;
            endcase
            @(negedge clk);
            chk("aux select", {7'h00, s}, {7'h00, aux});
        end
        wr(`UTAUX_OFF_ACR, 8'h07);
        foreach (tbl[i]) begin
            req.rx_full_sel <= tbl[i][2];
            req.rx_fifo_level <= tbl[i][1:0];
            s = tbl[i][2] ? (tbl[i][1:0] == 2'h3) : (tbl[i][1:0] != 2'h0);
            cyc(3);
            interrupt_status(d);
            chk("isr rx", {5'h00, s, 2'h3}, d);
            chk("aux rx", {7'h00, ~s}, {7'h00, aux});
        end
        $display("test select done");
    endtask

    task automatic t_counter();
        logic [7:0] d;
        wr(`UTAUX_OFF_ACR, 8'h01);
        wr(`UTAUX_OFF_PRESET_HIGH_BYTE, 8'h00);
        wr(`UTAUX_OFF_PRESET_LOW_BYTE, 8'h03);
        cmd(`UTAUX_CMD_START);
        repeat (2) pulse();
        chk("count run", 8'h01, {7'h00, aux});
        pulse();
        chk("count end", 8'h00, {7'h00, aux});
        interrupt_status(d);
        chk("ct ready", 8'h10, d & 8'h10);
        cmd(`UTAUX_CMD_STOP);
        cyc(2);
        chk("count stop", 8'h01, {7'h00, aux});
        interrupt_status(d);
        chk("ct cleared", 8'h00, d & 8'h10);
        cmd(`UTAUX_CMD_CLR_COS);
        $display("test counter done");
    endtask

    task automatic t_timer();
        int n;
        logic [7:0] d;
        wr(`UTAUX_OFF_PRESET_LOW_BYTE, 8'h28);
        wr(`UTAUX_OFF_ACR, 8'h61);
        span(1'b1, n);
        span(1'b0, n);
        span(1'b1, n);
        chk("timer high", 8'h28, 8'(n));
        interrupt_status(d);
        chk("timer ready", 8'h10, d & 8'h10);
        span(1'b0, n);
        cmd(`UTAUX_CMD_STOP);
        interrupt_status(d);
        chk("timer cleared", 8'h00, d & 8'h10);
        span(1'b1, n);
        span(1'b0, n);
        chk("timer runs", 8'h28, 8'(n));
        $display("test timer done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] d;
        repeat (2) @(posedge clk);
        chk("reset aux", 8'h01, {7'h00, aux});
        chk("reset irq", 8'h01, {7'h00, irq_n});
        rst_n <= 1'b1;
        interrupt_status(d);
        chk("reset isr", 8'h00, d);
        t_status();
        t_rts();
        t_osel();
        t_counter();
        t_timer();
        complete_run();
    end
    // a hang ends the run through the same closing task
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
